// >>> include/mofd_regs.vh
`ifndef MOFD_REGS_VH
`define MOFD_REGS_VH

// instruction formats, supplied by the core's opcode classifier
`define MOFD_FMT_NONE 4'h0
`define MOFD_FMT_BYTE 4'h1
`define MOFD_FMT_BIT 4'h2
`define MOFD_FMT_LIT 4'h3
`define MOFD_FMT_LFSR 4'h4
`define MOFD_FMT_MOVE 4'h5
`define MOFD_FMT_IDXMOVE 4'h6
`define MOFD_FMT_CALL 4'h7
`define MOFD_FMT_GOTO 4'h8
`define MOFD_FMT_RET 4'h9
`define MOFD_FMT_BRA 4'ha
`define MOFD_FMT_BCOND 4'hb
`define MOFD_FMT_TBL 4'hc

// field positions
`define MOFD_SECOND_TAG 4'hf
`define MOFD_POS_DEST 9
`define MOFD_POS_ACCESS 8
`define MOFD_POS_FAST 8
`define MOFD_POS_TBLWR 2

// literal widths
`define MOFD_LW_8 2'h0
`define MOFD_LW_12 2'h1
`define MOFD_LW_20 2'h2

// table pointer modes
`define MOFD_TM_NONE 2'h0
`define MOFD_TM_POSTINC 2'h1
`define MOFD_TM_POSTDEC 2'h2
`define MOFD_TM_PREINC 2'h3

// timing: clocks per instruction cycle, index of last phase
`define MOFD_LAST_PHASE 2'h3

// access RAM split within the file field
`define MOFD_ACCESS_SPLIT 8'h80
`define MOFD_ACCESS_HIGH_BANK 4'hf

// register map (byte addresses)
`define MOFD_OFS_BANK 8'h00
`define MOFD_OFS_ACC 8'h04
`define MOFD_OFS_TABLE_POINTER 8'h08
`define MOFD_OFS_TBLLATCH 8'h0c
`define MOFD_OFS_FLAGS 8'h10
`define MOFD_OFS_DECSTAT 8'h14

// reset values
`define MOFD_RST_BANK 4'h0
`define MOFD_RST_ACC 8'h00
`define MOFD_RST_TABLE_POINTER 21'h000000
`define MOFD_RST_TBLLATCH 8'h00
`define MOFD_RST_FLAGS 5'h00
`endif

// >>> rtl/mofd_field_extract.v
`include "mofd_regs.vh"

module mofd_field_extract (
  input wire [15:0] firstWord,
  input wire [15:0] secondWord,
  input wire [3:0] fmt,
  input wire [3:0] bankSel,
  input wire [20:0] pcNext,
  output reg [11:0] dataAddr,
  output reg [11:0] srcAddr,
  output reg [11:0] dstAddr,
  output reg destFile,
  output reg [2:0] bitPos,
  output reg [1:0] ptrSel,
  output reg [19:0] literal,
  output reg [1:0] litWidth,
  output reg [20:0] target,
  output reg fastBit,
  output reg [1:0] tblMode,
  output reg [6:0] srcOffset,
  output reg [6:0] dstOffset
);

  function [11:0] fileAddr;
    input accessBit;
    input [7:0] f;
    input [3:0] bank;
    begin
      if (accessBit) begin
        fileAddr = {bank, f};
      end else if (f < `MOFD_ACCESS_SPLIT) begin
        fileAddr = {4'h0, f};
      end else begin
        fileAddr = {`MOFD_ACCESS_HIGH_BANK, f};
      end
    end
  endfunction

  function [20:0] relTarget;
    input [20:0] pc;
    input [10:0] off;
    begin
      relTarget = pc + {{9{off[10]}}, off, 1'b0};
    end
  endfunction

  always @* begin
    dataAddr = fileAddr(firstWord[`MOFD_POS_ACCESS], firstWord[7:0], bankSel);
    srcAddr = firstWord[11:0];
    dstAddr = secondWord[11:0];
    destFile = 1'b0;
    bitPos = 3'h0;
    ptrSel = 2'h0;
    literal = {12'h000, firstWord[7:0]};
    litWidth = `MOFD_LW_8;
    target = 21'h000000;
    fastBit = 1'b0;
    tblMode = firstWord[1:0];
    srcOffset = firstWord[6:0];
    dstOffset = secondWord[6:0];
    case (fmt)
      `MOFD_FMT_BYTE: begin
        destFile = firstWord[`MOFD_POS_DEST];
      end
      `MOFD_FMT_BIT: begin
        bitPos = firstWord[11:9];
      end
      `MOFD_FMT_LFSR: begin
        ptrSel = firstWord[5:4];
        literal = {8'h00, firstWord[3:0], secondWord[7:0]};
        litWidth = `MOFD_LW_12;
      end
      `MOFD_FMT_MOVE: begin
        srcAddr = firstWord[11:0];
        dstAddr = secondWord[11:0];
      end
      `MOFD_FMT_CALL, `MOFD_FMT_GOTO: begin
        literal = {secondWord[11:0], firstWord[7:0]};
        litWidth = `MOFD_LW_20;
        target = {secondWord[11:0], firstWord[7:0], 1'b0};
        fastBit = (fmt == `MOFD_FMT_CALL) ? firstWord[`MOFD_POS_FAST] : 1'b0;
      end
      `MOFD_FMT_RET: begin
        fastBit = firstWord[0];
      end
      `MOFD_FMT_BRA: begin
        target = relTarget(pcNext, firstWord[10:0]);
      end
      `MOFD_FMT_BCOND: begin
        target = relTarget(pcNext, {{3{firstWord[7]}}, firstWord[7:0]});
      end
      default: begin
        literal = {12'h000, firstWord[7:0]};
      end
    endcase
  end

endmodule // mofd_field_extract

// >>> rtl/mofd_decoder.v
`include "mofd_regs.vh"

module mofd_decoder #(
  parameter PADDR_W = 8
) (
  input wire clk,
  input wire nrst,
  // fetch side
  input wire [15:0] fetchWord,
  input wire [3:0] fetchFmt,
  input wire [20:0] pcNext,
  // datapath results
  input wire resultValid,
  input wire [7:0] resultData,
  input wire flagValid,
  input wire [4:0] flagMask,
  input wire [4:0] flagValue,
  input wire tblReadValid,
  input wire [7:0] tblReadData,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [PADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // decoded fields
  output wire decValid,
  output wire decNop,
  output wire [3:0] decFmt,
  output wire [11:0] dataAddr,
  output wire writeAcc,
  output wire writeFile,
  output wire [2:0] bitPos,
  output wire [1:0] ptrSel,
  output wire [11:0] srcAddr,
  output wire [11:0] dstAddr,
  output wire [6:0] srcOffset,
  output wire [6:0] dstOffset,
  output wire [19:0] literal,
  output wire [1:0] litWidth,
  output wire [20:0] target,
  output wire fastSave,
  output wire fastRestore,
  output wire tblRead,
  output wire tblWrite,
  output wire [20:0] tblAddr,
  output wire [7:0] tblWriteData,
  output wire [7:0] accValue,
  output wire [4:0] aluFlags,
  output wire [3:0] bankSel
);

  reg [1:0] phase_q;
  reg pending_q;
  reg [15:0] firstWord_q;
  reg [3:0] firstFmt_q;
  reg [15:0] exWord1;
  reg [15:0] exWord2;
  reg [3:0] exFmt;
  wire boundary;
  reg decodeNow;
  reg lonePad;

  wire [11:0] xDataAddr;
  wire [11:0] xSrcAddr;
  wire [11:0] xDstAddr;
  wire xDestFile;
  wire [2:0] xBitPos;
  wire [1:0] xPtrSel;
  wire [19:0] xLiteral;
  wire [1:0] xLitWidth;
  wire [20:0] xTarget;
  wire xFast;
  wire [1:0] xTblMode;
  wire [6:0] xSrcOffset;
  wire [6:0] xDstOffset;

  reg decValid_q;
  reg decNop_q;
  reg [3:0] decFmt_q;
  reg [11:0] dataAddr_q;
  reg writeAcc_q;
  reg writeFile_q;
  reg [2:0] bitPos_q;
  reg [1:0] ptrSel_q;
  reg [11:0] srcAddr_q;
  reg [11:0] dstAddr_q;
  reg [6:0] srcOffset_q;
  reg [6:0] dstOffset_q;
  reg [19:0] literal_q;
  reg [1:0] litWidth_q;
  reg [20:0] target_q;
  reg fastSave_q;
  reg fastRestore_q;
  reg tblRead_q;
  reg tblWrite_q;
  reg [20:0] tblAddr_q;

  reg [3:0] bank_q;
  reg [7:0] acc_q;
  reg [20:0] table_pointer_q;
  reg [20:0] table_pointer_d;
  reg [20:0] tblAddr_d;
  reg [7:0] tblLatch_q;
  reg [4:0] flags_q;

  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] rdMux;
  reg rdHit;
  wire apbStart;
  wire apbDone;
  wire apbWr;

  // at most one decode per four-clock instruction cycle; none while a first word waits for its second
  assign boundary = (phase_q == `MOFD_LAST_PHASE);

  always @(posedge clk) begin
    if (!nrst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // pairing of first and second words
  always @* begin
    exWord1 = fetchWord;
    exWord2 = 16'h0000;
    exFmt = fetchFmt;
    decodeNow = 1'b0;
    lonePad = 1'b0;
    if (boundary) begin
      if (pending_q) begin
        exWord1 = firstWord_q;
        exWord2 = fetchWord;
        exFmt = firstFmt_q;
        decodeNow = (fetchWord[15:12] == `MOFD_SECOND_TAG);
        lonePad = ~decodeNow;
      end else if (fetchWord[15:12] == `MOFD_SECOND_TAG) begin
        lonePad = 1'b1;
      end else if (fetchFmt == `MOFD_FMT_LFSR || fetchFmt == `MOFD_FMT_MOVE ||
                   fetchFmt == `MOFD_FMT_IDXMOVE || fetchFmt == `MOFD_FMT_CALL ||
                   fetchFmt == `MOFD_FMT_GOTO) begin
        decodeNow = 1'b0;
      end else begin
        decodeNow = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      pending_q <= 1'b0;
      firstWord_q <= 16'h0000;
      firstFmt_q <= `MOFD_FMT_NONE;
    end else if (boundary) begin
      if (pending_q || lonePad || decodeNow) begin
        pending_q <= 1'b0;
      end else begin
        pending_q <= 1'b1;
        firstWord_q <= fetchWord;
        firstFmt_q <= fetchFmt;
      end
    end
  end

  mofd_field_extract u_extract (
    .firstWord(exWord1),
    .secondWord(exWord2),
    .fmt(exFmt),
    .bankSel(bank_q),
    .pcNext(pcNext),
    .dataAddr(xDataAddr),
    .srcAddr(xSrcAddr),
    .dstAddr(xDstAddr),
    .destFile(xDestFile),
    .bitPos(xBitPos),
    .ptrSel(xPtrSel),
    .literal(xLiteral),
    .litWidth(xLitWidth),
    .target(xTarget),
    .fastBit(xFast),
    .tblMode(xTblMode),
    .srcOffset(xSrcOffset),
    .dstOffset(xDstOffset)
  );

  // table pointer stepping
  always @* begin
    table_pointer_d = table_pointer_q;
    tblAddr_d = table_pointer_q;
    case (xTblMode)
      `MOFD_TM_POSTINC: begin
        table_pointer_d = table_pointer_q + 21'h000001;
      end
      `MOFD_TM_POSTDEC: begin
        table_pointer_d = table_pointer_q - 21'h000001;
      end
      `MOFD_TM_PREINC: begin
        table_pointer_d = table_pointer_q + 21'h000001;
        tblAddr_d = table_pointer_q + 21'h000001;
      end
      default: begin
        table_pointer_d = table_pointer_q;
      end
    endcase
  end

  // decoded fields held for the whole instruction cycle
  always @(posedge clk) begin
    if (!nrst) begin
      decValid_q <= 1'b0;
      decNop_q <= 1'b0;
      decFmt_q <= `MOFD_FMT_NONE;
      dataAddr_q <= 12'h000;
      writeAcc_q <= 1'b0;
      writeFile_q <= 1'b0;
      bitPos_q <= 3'h0;
      ptrSel_q <= 2'h0;
      srcAddr_q <= 12'h000;
      dstAddr_q <= 12'h000;
      srcOffset_q <= 7'h00;
      dstOffset_q <= 7'h00;
      literal_q <= 20'h00000;
      litWidth_q <= `MOFD_LW_8;
      target_q <= 21'h000000;
      fastSave_q <= 1'b0;
      fastRestore_q <= 1'b0;
      tblRead_q <= 1'b0;
      tblWrite_q <= 1'b0;
      tblAddr_q <= `MOFD_RST_TABLE_POINTER;
    end else begin
      decValid_q <= decodeNow | lonePad;
      if (decodeNow | lonePad) begin
        decNop_q <= lonePad;
        decFmt_q <= lonePad ? `MOFD_FMT_NONE : exFmt;
        dataAddr_q <= xDataAddr;
        writeAcc_q <= decodeNow && exFmt == `MOFD_FMT_BYTE && !xDestFile;
        writeFile_q <= decodeNow && exFmt == `MOFD_FMT_BYTE && xDestFile;
        bitPos_q <= xBitPos;
        ptrSel_q <= xPtrSel;
        srcAddr_q <= xSrcAddr;
        dstAddr_q <= xDstAddr;
        srcOffset_q <= xSrcOffset;
        dstOffset_q <= xDstOffset;
        literal_q <= xLiteral;
        litWidth_q <= xLitWidth;
        target_q <= xTarget;
        fastSave_q <= decodeNow && exFmt == `MOFD_FMT_CALL && xFast;
        fastRestore_q <= decodeNow && exFmt == `MOFD_FMT_RET && xFast;
        tblRead_q <= decodeNow && exFmt == `MOFD_FMT_TBL && !exWord1[`MOFD_POS_TBLWR];
        tblWrite_q <= decodeNow && exFmt == `MOFD_FMT_TBL && exWord1[`MOFD_POS_TBLWR];
        if (decodeNow && exFmt == `MOFD_FMT_TBL) begin
          tblAddr_q <= tblAddr_d;
        end
      end
    end
  end

  // apb: access phase lasts two cycles, write commits when pready is high
  assign apbStart = psel & penable & ~pready_q;
  assign apbDone = psel & penable & pready_q;
  assign apbWr = apbDone & pwrite & ~pslverr_q;

  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (paddr)
      `MOFD_OFS_BANK: rdMux = {28'h0000000, bank_q};
      `MOFD_OFS_ACC: rdMux = {24'h000000, acc_q};
      `MOFD_OFS_TABLE_POINTER: rdMux = {11'h000, table_pointer_q};
      `MOFD_OFS_TBLLATCH: rdMux = {24'h000000, tblLatch_q};
      `MOFD_OFS_FLAGS: rdMux = {27'h0000000, flags_q};
      `MOFD_OFS_DECSTAT: rdMux = {26'h0000000, phase_q, pending_q, decFmt_q[2:0]};
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apbStart;
      pslverr_q <= apbStart & ~rdHit;
      if (apbStart) begin
        prdata_q <= pwrite ? 32'h00000000 : rdMux;
      end
    end
  end

  // core state; datapath updates win over software writes
  always @(posedge clk) begin
    if (!nrst) begin
      bank_q <= `MOFD_RST_BANK;
      acc_q <= `MOFD_RST_ACC;
      table_pointer_q <= `MOFD_RST_TABLE_POINTER;
      tblLatch_q <= `MOFD_RST_TBLLATCH;
      flags_q <= `MOFD_RST_FLAGS;
    end else begin
      if (apbWr && paddr == `MOFD_OFS_BANK) begin
        bank_q <= pwdata[3:0];
      end
      if (resultValid && writeAcc_q) begin
        acc_q <= resultData;
      end else if (apbWr && paddr == `MOFD_OFS_ACC) begin
        acc_q <= pwdata[7:0];
      end
      if (decodeNow && exFmt == `MOFD_FMT_TBL) begin
        table_pointer_q <= table_pointer_d;
      end else if (apbWr && paddr == `MOFD_OFS_TABLE_POINTER) begin
        table_pointer_q <= pwdata[20:0];
      end
      if (tblReadValid) begin
        tblLatch_q <= tblReadData;
      end else if (apbWr && paddr == `MOFD_OFS_TBLLATCH) begin
        tblLatch_q <= pwdata[7:0];
      end
      if (flagValid) begin
        flags_q <= (flags_q & ~flagMask) | (flagValue & flagMask);
      end else if (apbWr && paddr == `MOFD_OFS_FLAGS) begin
        flags_q <= pwdata[4:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign decValid = decValid_q;
  assign decNop = decNop_q;
  assign decFmt = decFmt_q;
  assign dataAddr = dataAddr_q;
  assign writeAcc = writeAcc_q;
  assign writeFile = writeFile_q;
  assign bitPos = bitPos_q;
  assign ptrSel = ptrSel_q;
  assign srcAddr = srcAddr_q;
  assign dstAddr = dstAddr_q;
  assign srcOffset = srcOffset_q;
  assign dstOffset = dstOffset_q;
  assign literal = literal_q;
  assign litWidth = litWidth_q;
  assign target = target_q;
  assign fastSave = fastSave_q;
  assign fastRestore = fastRestore_q;
  assign tblRead = tblRead_q;
  assign tblWrite = tblWrite_q;
  assign tblAddr = tblAddr_q;
  assign tblWriteData = tblLatch_q;
  assign accValue = acc_q;
  assign aluFlags = flags_q;
  assign bankSel = bank_q;

endmodule // mofd_decoder

// >>> dv/mofd_decoder_chk.sv
`include "mofd_regs.vh"

module mofd_decoder_chk (
  input logic clk,
  input logic nrst,
  input logic resultValid,
  input logic [7:0] resultData,
  input logic flagValid,
  input logic [4:0] flagMask,
  input logic [4:0] flagValue,
  input logic decValid,
  input logic decNop,
  input logic [3:0] decFmt,
  input logic [11:0] dataAddr,
  input logic writeAcc,
  input logic writeFile,
  input logic [20:0] target,
  input logic tblRead,
  input logic tblWrite,
  input logic [7:0] accValue,
  input logic [4:0] aluFlags,
  input logic [3:0] bankSel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic byteDec;
  assign byteDec = decValid && decFmt == `MOFD_FMT_BYTE && !decNop;
  dec_spacing_a: assert property (decValid |=> !decValid [*3])
    else $error("decode strobes closer than four cycles");
  field_hold_a: assert property (
    !decValid |-> $stable(dataAddr) && $stable(target))
    else $error("fields moved without a decode");
  dest_sel_a: assert property (byteDec |-> writeAcc != writeFile)
    else $error("byte result target not exclusive");
  access_ram_a: assert property (
    byteDec && dataAddr[11:8] != bankSel |-> dataAddr[11:8] == {4{dataAddr[7]}})
    else $error("access bank wrong");
  nop_quiet_a: assert property (
    decValid && decNop |-> !(writeAcc || writeFile || tblRead || tblWrite))
    else $error("lone second word had an effect");
  tbl_excl_a: assert property (decValid |-> !(tblRead && tblWrite))
    else $error("table read and write together");
  acc_load_a: assert property (
    resultValid && writeAcc |=> accValue == $past(resultData))
    else $error("accumulator not loaded");
  flag_upd_a: assert property (
    flagValid |=> aluFlags ==
      ($past(aluFlags) & ~$past(flagMask) | $past(flagValue) & $past(flagMask)))
    else $error("flag update wrong");
  cover property (decValid && decNop);
  cover property (decValid && tblWrite);
  cover property (resultValid && writeAcc);
endmodule // mofd_decoder_chk

bind mofd_decoder mofd_decoder_chk u_chk (.clk, .nrst, .resultValid, .resultData, .flagValid,
  .flagMask, .flagValue, .decValid, .decNop, .decFmt, .dataAddr, .writeAcc, .writeFile,
  .target, .tblRead, .tblWrite, .accValue, .aluFlags, .bankSel);

// >>> dv/mofd_fetch_model.sv
module mofd_fetch_model (
  input logic clk,
  input logic nrst,
  output logic [15:0] fetchWord,
  output logic [3:0] fetchFmt,
  output logic [20:0] pcNext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] prog [32];
  logic [3:0] fmt [32];
  logic [1:0] phase_q;
  logic [4:0] idx_q;
  always @(posedge clk) begin
    if (!nrst) begin
      phase_q <= 2'h0;
      idx_q <= 5'h00;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3 && idx_q != 5'h1f) idx_q <= idx_q + 5'h01;
    end
  end
  // scrambled off the boundary so an early sample shows up
  assign fetchWord = (phase_q == 2'h3) ? prog[idx_q] : ~prog[idx_q];
  assign fetchFmt = (phase_q == 2'h3) ? fmt[idx_q] : ~fmt[idx_q];
  assign pcNext = 21'h000100 + {idx_q, 1'b0};
endmodule // mofd_fetch_model

// >>> dv/tb.sv
`include "mofd_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // program from slot 8 on, with the format code of each word
  localparam logic [0:22][15:0] PW = {16'h247f, 16'h2680, 16'h2712, 16'h8fff, 16'h0e7f,
    16'hee2a, 16'hf0bc, 16'hc123, 16'hffed, 16'hed34, 16'hf567, 16'hf00f, 16'hd7ff,
    16'he280, 16'h0013, 16'h000b, 16'h000e, 16'h0008, 16'h0009, 16'he845, 16'hf0a3,
    16'hef12, 16'hf345};
  localparam logic [0:22][3:0] PF = 92'h111234050701ab9cccc6080;
  logic clk = 1'b0, nrst = 1'b0, resultValid = 1'b0, flagValid = 1'b0, tblReadValid = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] resultData = 8'h00, tblReadData = 8'h00, paddr = 8'h00, tblWriteData, accValue;
  logic [4:0] flagMask = 5'h00, flagValue = 5'h00, aluFlags;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] fetchWord;
  logic [3:0] fetchFmt, decFmt, bankSel;
  logic [20:0] pcNext, target, tblAddr;
  logic [11:0] dataAddr, srcAddr, dstAddr;
  logic [19:0] literal;
  logic [2:0] bitPos;
  logic [1:0] ptrSel, litWidth;
  logic [6:0] srcOffset, dstOffset;
  logic pready, pslverr, decValid, decNop, writeAcc, writeFile;
  logic fastSave, fastRestore, tblRead, tblWrite;
  int numErrors = 0, compares = 0, cycles = 0;

  mofd_fetch_model u_fm (.clk, .nrst, .fetchWord, .fetchFmt, .pcNext);
  mofd_decoder u_dut (.clk, .nrst, .fetchWord, .fetchFmt, .pcNext, .resultValid, .resultData,
    .flagValid, .flagMask, .flagValue, .tblReadValid, .tblReadData, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .decValid, .decNop, .decFmt, .dataAddr,
    .writeAcc, .writeFile, .bitPos, .ptrSel, .srcAddr, .dstAddr, .srcOffset, .dstOffset,
    .literal, .litWidth, .target, .fastSave, .fastRestore, .tblRead, .tblWrite, .tblAddr,
    .tblWriteData, .accValue, .aluFlags, .bankSel);

  always #5 clk = ~clk;

  task testDone;
    if (numErrors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      numErrors++;
      testDone;
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task nextDec;
    do @(posedge clk);
    while (decValid !== 1'b1 || (decFmt === `MOFD_FMT_NONE && decNop !== 1'b1));
  endtask

  task tRegs;
    logic [31:0] r;
    logic e;
    apb(1'b1, `MOFD_OFS_BANK, 32'hfffffff5, r, e);
    apb(1'b1, `MOFD_OFS_TABLE_POINTER, 32'hffe0ffff, r, e);
    apb(1'b0, `MOFD_OFS_BANK, 32'h0, r, e);
    chk("bank", 32'h5, r);
    chk("bsel", 32'h5, bankSel);
    chk("ok", 32'h0, e);
    apb(1'b0, `MOFD_OFS_TABLE_POINTER, 32'h0, r, e);
    chk("tptr", 32'h00ffff, r);
    apb(1'b0, `MOFD_OFS_FLAGS, 32'h0, r, e);
    chk("flags", 32'h0, r);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("err", 32'h1, e);
    chk("rdata", 32'h0, r);
  endtask

  task tFile;
    nextDec;
    chk("addr", 32'h07f, dataAddr);
    chk("fmt", `MOFD_FMT_BYTE, decFmt);
    chk("wacc", 32'h1, writeAcc);
    nextDec;
    chk("addr", 32'hf80, dataAddr);
    chk("wfile", 32'h1, writeFile);
    chk("wacc", 32'h0, writeAcc);
    nextDec;
    chk("addr", 32'h512, dataAddr);
    nextDec;
    chk("addr", 32'h5ff, dataAddr);
    chk("bit", 32'h7, bitPos);
    nextDec;
    chk("lit", 32'h7f, literal);
    chk("lwid", `MOFD_LW_8, litWidth);
  endtask

  task tTwoWord;
    nextDec;
    chk("ptr", 32'h2, ptrSel);
    chk("lit", 32'habc, literal);
    chk("lwid", `MOFD_LW_12, litWidth);
    nextDec;
    chk("src", 32'h123, srcAddr);
    chk("dst", 32'hfed, dstAddr);
    chk("nop", 32'h0, decNop);
    nextDec;
    chk("tgt", 32'h0ace68, target);
    chk("lwid", `MOFD_LW_20, litWidth);
    chk("fsav", 32'h1, fastSave);
    nextDec;
    chk("nop", 32'h1, decNop);
    chk("fmt", `MOFD_FMT_NONE, decFmt);
  endtask

  task tBranch;
    nextDec;
    chk("tgt", 32'h126, target);
    nextDec;
    chk("tgt", 32'h02a, target);
    nextDec;
    chk("frst", 32'h1, fastRestore);
    chk("fsav", 32'h0, fastSave);
  endtask

  task tTable;
    for (int i = 0; i < 4; i++) begin
      nextDec;
      chk("taddr", (i < 2) ? 32'h010000 : 32'h00ffff, tblAddr);
      chk("twr", (i == 1) ? 32'h1 : 32'h0, tblWrite);
      chk("trd", (i == 1) ? 32'h0 : 32'h1, tblRead);
    end
  endtask

  task tLong;
    nextDec;
    chk("soff", 32'h45, srcOffset);
    chk("doff", 32'h23, dstOffset);
    nextDec;
    chk("tgt", 32'h068a24, target);
    chk("lwid", `MOFD_LW_20, litWidth);
    chk("fsav", 32'h0, fastSave);
  endtask

  task tPath;
    logic [31:0] r;
    logic e;
    do @(posedge clk);
    while (writeAcc !== 1'b1);
    resultValid <= 1'b1;
    resultData <= 8'h5a;
    flagValid <= 1'b1;
    flagMask <= 5'h15;
    flagValue <= 5'h1f;
    tblReadValid <= 1'b1;
    tblReadData <= 8'hc3;
    @(posedge clk);
    resultValid <= 1'b0;
    flagValid <= 1'b0;
    tblReadValid <= 1'b0;
    apb(1'b0, `MOFD_OFS_ACC, 32'h0, r, e);
    chk("acc", 32'h5a, r);
    apb(1'b0, `MOFD_OFS_FLAGS, 32'h0, r, e);
    chk("flags", 32'h15, r);
    apb(1'b0, `MOFD_OFS_TBLLATCH, 32'h0, r, e);
    chk("latch", 32'hc3, r);
    apb(1'b0, `MOFD_OFS_TABLE_POINTER, 32'h0, r, e);
    chk("tptr", 32'h010000, r);
    chk("accv", 32'h5a, accValue);
    chk("flgv", 32'h15, aluFlags);
    chk("twd", 32'hc3, tblWriteData);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) begin
      u_fm.prog[i] = (i < 8) ? 16'h0000 : (i < 31) ? PW[i-8] : 16'h2405;
      u_fm.fmt[i] = (i < 8) ? `MOFD_FMT_NONE : (i < 31) ? PF[i-8] : `MOFD_FMT_BYTE;
    end
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    tRegs;
    tFile;
    tTwoWord;
    tBranch;
    tTable;
    tLong;
    tPath;
    testDone;
  end
endmodule // tb
